// File: verilog/ppl_probe_latch.sv
// ppl_probe_latch: two channel probe position capture with registers.
// assumes probe pins and encoder zero pulse are asynchronous, the
// feedback position is on core_clk, and a single strobe master.
//
// Local design decision: the strobed register port.

// Summary of operation
// R1: channel one rise latches position holder
// R2: channel one fall latches separate holder
// R3: channel two rise latches its holder
// R4: channel two fall latches its holder
// R5: pin index 0..2, defaults 0/1, on restart
// R6: filter 0..1000 of 10 ns, immediate
// R7: per channel polarity, applied on restart
// R8: capture needs enable and edge enable
// R9: single captures first event, continuous every
// R10: source bit picks probe or encoder zero
// R11: continuous mode two-bit count wraps
// R12: stable for filter time; zero passes through
module ppl_probe_latch (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // probe pins and encoder
    input wire logic [ppl_pkg::NPIN-1:0] probe_pin,
    input wire logic enc_zero,
    input wire logic signed [31:0] fb_position,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt
    output logic irq
);
    import ppl_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [NPIN:0] in_meta;
    logic [NPIN:0] in_sync;
    logic [15:0] ctrl;
    logic [2*PINSEL_W-1:0] pinsel;
    logic [9:0] filt_time;
    logic [NCH-1:0] pol;
    logic [PINSEL_W-1:0] act_pin [NCH];
    logic [NCH-1:0] act_pol;
    logic [10:0] filt_thr;
    logic [15:0] filt_prod;
    logic [10:0] filt_cnt [NCH];
    logic [NCH-1:0] filt_state;
    logic [NCH-1:0] raw;
    logic [NCH-1:0] filt_out;
    logic [NCH-1:0] trig;
    logic [NCH-1:0] trig_prev;
    logic [NCH-1:0] en;
    logic [NCH-1:0] cont;
    logic [NCH-1:0] cap_r;
    logic [NCH-1:0] cap_f;
    logic [NCH-1:0] sto_r;
    logic [NCH-1:0] sto_f;
    logic [1:0] exec_cnt [NCH];
    logic signed [31:0] pos_hold [NHOLD];
    logic [15:0] status;
    logic [NHOLD-1:0] irq_stat;
    logic [NHOLD-1:0] irq_mask;
    logic [NHOLD-1:0] events;
    logic [31:0] next_rdata;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // two flops on each pin and on the encoder zero pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_meta <= SYNC_RST; // idle levels, no false edge
            in_sync <= SYNC_RST;
        end else begin
            in_meta <= {enc_zero, probe_pin};
            in_sync <= in_meta;
        end
    end

    // ************************************************************
    // software registers
    // ************************************************************
    // control word and probe parameters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
            pinsel <= PINSEL_RST;
            filt_time <= FILT_RST;
            pol <= POL_RST;
            irq_mask <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_CTRL: ctrl <= reg_wdata[15:0];
                ADDR_PINSEL: pinsel <= reg_wdata[2*PINSEL_W-1:0];
                ADDR_FILT: filt_time <= (reg_wdata > 32'(FILT_MAX))
                    ? FILT_MAX : reg_wdata[9:0]; // R6
                ADDR_POL: pol <= reg_wdata[NCH-1:0];
                ADDR_IRQ_MASK: irq_mask <= reg_wdata[NHOLD-1:0];
                default: ;
            endcase
        end
    end

    // pin and polarity take effect only while the channel is off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_pin[0] <= PINSEL_RST[PINSEL_W-1:0]; // R5
            act_pin[1] <= PINSEL_RST[2*PINSEL_W-1:PINSEL_W]; // R5
            act_pol <= POL_RST; // R7
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (!en[c]) begin
                    act_pin[c] <= pinsel[c*PINSEL_W +: PINSEL_W]; // R5
                    act_pol[c] <= pol[c]; // R7
                end
            end
        end
    end

    // ************************************************************
    // filter threshold in cycles, rounded up
    // ************************************************************
    assign filt_prod = 16'(filt_time) * FILT_UNIT_NS;
    assign filt_thr = 11'((filt_prod + CLK_PERIOD_NS - 16'h0001)
        / CLK_PERIOD_NS); // R6

    // ************************************************************
    // per channel trigger path
    // ************************************************************
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign en[c] = ctrl[c*CH_STRIDE + CTL_EN];
        assign cont[c] = ctrl[c*CH_STRIDE + CTL_CONT];
        // pin allocation, unknown index falls back to pin 0
        assign raw[c] = (act_pin[c] == PIN2) ? in_sync[2] :
            (act_pin[c] == PIN1) ? in_sync[1] : in_sync[0]; // R5
        assign filt_out[c] = (filt_thr == '0) ? raw[c]
            : filt_state[c]; // R12
        // polarity, then source choice
        assign trig[c] = ctrl[c*CH_STRIDE + CTL_SRC] ? in_sync[NPIN]
            : (act_pol[c] ? filt_out[c] : ~filt_out[c]); // R7 R10
        assign cap_r[c] = en[c] && ctrl[c*CH_STRIDE + CTL_RISE]
            && trig[c] && !trig_prev[c] && (cont[c] || !sto_r[c]); // R8 R9
        assign cap_f[c] = en[c] && ctrl[c*CH_STRIDE + CTL_FALL]
            && !trig[c] && trig_prev[c] && (cont[c] || !sto_f[c]); // R8 R9
        assign events[2*c] = cap_r[c];
        assign events[2*c+1] = cap_f[c];
    end

    // glitch filter: accept a new level after filt_thr steady cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_state <= '1; // matches idle probe pins
            for (int c = 0; c < NCH; c++) filt_cnt[c] <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (raw[c] == filt_state[c]) begin
                    filt_cnt[c] <= '0;
                end else if (filt_cnt[c] + 11'h001 >= filt_thr) begin
                    filt_state[c] <= raw[c]; // R12
                    filt_cnt[c] <= '0;
                end else begin
                    filt_cnt[c] <= filt_cnt[c] + 11'h001; // R12
                end
            end
        end
    end

    // edge history of the trigger
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev <= '0;
        end else begin
            trig_prev <= trig;
        end
    end

    // ************************************************************
    // capture holders and channel status
    // ************************************************************
    // latch feedback position on a qualified edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int h = 0; h < NHOLD; h++) pos_hold[h] <= '0;
        end else begin
            if (cap_r[0]) pos_hold[0] <= fb_position; // R1
            if (cap_f[0]) pos_hold[1] <= fb_position; // R2
            if (cap_r[1]) pos_hold[2] <= fb_position; // R3
            if (cap_f[1]) pos_hold[3] <= fb_position; // R4
        end
    end

    // stored flags and execution count, cleared while disabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sto_r <= '0;
            sto_f <= '0;
            for (int c = 0; c < NCH; c++) exec_cnt[c] <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (!en[c]) begin
                    sto_r[c] <= 1'b0;
                    sto_f[c] <= 1'b0;
                    exec_cnt[c] <= '0;
                end else begin
                    if (cap_r[c]) sto_r[c] <= 1'b1; // R9
                    if (cap_f[c]) sto_f[c] <= 1'b1; // R9
                    if (cont[c] && (cap_r[c] || cap_f[c])) begin
                        exec_cnt[c] <= exec_cnt[c] + 2'h1; // R11
                    end
                end
            end
        end
    end

    // status word image
    always_comb begin
        status = '0;
        for (int c = 0; c < NCH; c++) begin
            status[c*CH_STRIDE + ST_EN] = en[c];
            status[c*CH_STRIDE + ST_RSTO] = sto_r[c];
            status[c*CH_STRIDE + ST_FSTO] = sto_f[c];
            status[c*CH_STRIDE + ST_CNT +: 2] = exec_cnt[c]; // R11
        end
    end

    // ************************************************************
    // interrupt
    // ************************************************************
    // sticky events, read clears, a new event wins over the clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= '0;
        end else if (reg_rd && reg_addr == ADDR_IRQ_STAT) begin
            irq_stat <= events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ************************************************************
    // read port
    // ************************************************************
    // read data selection, unmapped reads return zero
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            ADDR_CTRL: next_rdata = 32'(ctrl);
            ADDR_STAT: next_rdata = 32'(status);
            ADDR_RISE1: next_rdata = pos_hold[0];
            ADDR_FALL1: next_rdata = pos_hold[1];
            ADDR_RISE2: next_rdata = pos_hold[2];
            ADDR_FALL2: next_rdata = pos_hold[3];
            ADDR_PINSEL: next_rdata = 32'(pinsel);
            ADDR_FILT: next_rdata = 32'(filt_time);
            ADDR_POL: next_rdata = 32'(pol);
            ADDR_IRQ_STAT: next_rdata = 32'(irq_stat);
            ADDR_IRQ_MASK: next_rdata = 32'(irq_mask);
            default: next_rdata = '0;
        endcase
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : '0;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    rise1_hold_a: assert property (cap_r[0] |=> // R1
        pos_hold[0] == $past(fb_position))
        else $error("rise one holder missed capture");
    fall1_hold_a: assert property (cap_f[0] |=> // R2
        pos_hold[1] == $past(fb_position) && $stable(pos_hold[0]))
        else $error("fall one holder missed capture");
    rise2_hold_a: assert property (cap_r[1] |=> // R3
        pos_hold[2] == $past(fb_position))
        else $error("rise two holder missed capture");
    fall2_hold_a: assert property (cap_f[1] |=> // R4
        pos_hold[3] == $past(fb_position) && $stable(pos_hold[2]))
        else $error("fall two holder missed capture");
    hold_quiet_a: assert property (!cap_r[0] |=> // R8
        $stable(pos_hold[0]))
        else $error("holder changed without capture");
    cap_enable_a: assert property ((cap_r[1] || cap_f[1]) |-> // R8
        ctrl[CH_STRIDE + CTL_EN])
        else $error("capture on disabled channel");
    single_once_a: assert property ((cap_r[0] && !cont[0]) |=> // R9
        sto_r[0] && !cap_r[0])
        else $error("single mode captured twice");
    cont_count_a: assert property ((cont[0] && cap_r[0]) |=> // R11
        exec_cnt[0] == $past(exec_cnt[0]) + 2'h1)
        else $error("execution count did not step");
    src_enc_a: assert property (ctrl[CTL_SRC] |-> // R10
        trig[0] == in_sync[NPIN])
        else $error("encoder source not selected");
    filt_pass_a: assert property ((filt_thr == '0) |-> // R12
        filt_out[0] == raw[0])
        else $error("zero filter delayed input");
    filt_steady_a: assert property (filt_thr > 11'h001 && // R12
        raw[0] != filt_state[0] && filt_cnt[0] == '0 |=>
        $stable(filt_state[0]))
        else $error("filter accepted a glitch");
    filt_range_a: assert property (filt_time <= FILT_MAX) // R6
        else $error("filter time out of range");

endmodule : ppl_probe_latch

// File: verilog/ppl_pkg.sv
// ppl_pkg: constants shared by the probe position latch.
// assumes a 125 MHz core clock and a plain strobe register port.
package ppl_pkg;

    // ************************************************************
    // sizes and timing
    // ************************************************************
    localparam int NCH = 2;
    localparam int NPIN = 3;
    localparam int NHOLD = 4;
    localparam int CH_STRIDE = 8;
    localparam logic [15:0] CLK_PERIOD_NS = 16'h0008;
    localparam logic [15:0] FILT_UNIT_NS = 16'h000a;
    localparam logic [9:0] FILT_MAX = 10'h3e8;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [15:0] ADDR_CTRL = 16'h60b8;
    localparam logic [15:0] ADDR_STAT = 16'h60b9;
    localparam logic [15:0] ADDR_RISE1 = 16'h60ba;
    localparam logic [15:0] ADDR_FALL1 = 16'h60bb;
    localparam logic [15:0] ADDR_RISE2 = 16'h60bc;
    localparam logic [15:0] ADDR_FALL2 = 16'h60bd;
    localparam logic [15:0] ADDR_PINSEL = 16'h0331;
    localparam logic [15:0] ADDR_FILT = 16'h0332;
    localparam logic [15:0] ADDR_POL = 16'h0333;
    localparam logic [15:0] ADDR_IRQ_STAT = 16'h6100;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h6101;

    // ************************************************************
    // field positions, per channel offset by CH_STRIDE
    // ************************************************************
    localparam int CTL_EN = 0;
    localparam int CTL_CONT = 1;
    localparam int CTL_SRC = 2;
    localparam int CTL_RISE = 4;
    localparam int CTL_FALL = 5;
    localparam int ST_EN = 0;
    localparam int ST_RSTO = 1;
    localparam int ST_FSTO = 2;
    localparam int ST_CNT = 6;
    localparam int PINSEL_W = 2;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [3:0] PINSEL_RST = 4'h4;
    localparam logic [9:0] FILT_RST = 10'h000;
    localparam logic [1:0] POL_RST = 2'h0;
    // synchroniser idle: probe pins high, encoder zero low
    localparam logic [3:0] SYNC_RST = 4'h7;
    localparam logic [1:0] PIN1 = 2'h1;
    localparam logic [1:0] PIN2 = 2'h2;

endpackage : ppl_pkg

// File: bench/ppl_probe_model.sv
// ppl_probe_model: probe switches and motor encoder beside the latch.
// assumes the bench calls its tasks; all changes land after core_clk rises.
module ppl_probe_model (
    // clock
    input wire logic core_clk,
    // probe switches and encoder
    output logic [ppl_pkg::NPIN-1:0] probe_pin,
    output logic enc_zero,
    output logic signed [31:0] fb_position
);
    timeunit 1ns;
    timeprecision 1ps;

    // switches open (high), encoder index low, axis at zero
    initial begin
        probe_pin = 3'h7;
        enc_zero = 1'b0;
        fb_position = 32'sh0;
    end

    // level change on one pin, index 3 is the encoder zero pulse
    task automatic drive(input int i, input logic v);
        @(posedge core_clk);
        if (i == 3) begin
            enc_zero <= v;
        end else begin
            probe_pin[i] <= v;
        end
    endtask : drive

    // axis moves to a new feedback position
    task automatic set_fb(input logic [31:0] v);
        @(posedge core_clk);
        fb_position <= v;
    endtask : set_fb
endmodule : ppl_probe_model

// File: bench/tb_ppl_probe_latch.sv
// tb_ppl_probe_latch: self-checking bench for the probe position latch.
// assumes ppl_pkg and the partner model are compiled first.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    num_errors++; $display("mismatch %0t: got %h want %h", $time, a, b); \
    end end
module tb_ppl_probe_latch;
    timeunit 1ns;
    timeprecision 1ps;
    import ppl_pkg::*;

    logic core_clk, rst_n, enc_zero, reg_wr, reg_rd, irq, rd_d;
    logic [NPIN-1:0] probe_pin;
    logic signed [31:0] fb_position;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed, exp_w;
    logic [31:0] fb [9];
    logic [31:0] exp_q [$];
    int num_errors, total_checks;
    logic [15:0] ra [12] = '{ADDR_CTRL, ADDR_STAT, ADDR_RISE1, ADDR_FALL1,
        ADDR_RISE2, ADDR_FALL2, ADDR_PINSEL, ADDR_FILT, ADDR_POL,
        ADDR_IRQ_STAT, ADDR_IRQ_MASK, 16'h1234};

    ppl_probe_latch u_ppl_probe_latch (.core_clk(core_clk), .rst_n(rst_n),
        .probe_pin(probe_pin), .enc_zero(enc_zero),
        .fb_position(fb_position), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    ppl_probe_model u_ppl_probe_model (.core_clk(core_clk),
        .probe_pin(probe_pin), .enc_zero(enc_zero),
        .fb_position(fb_position));

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read strobe; the expected word waits in the queue
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge core_clk);
        exp_q.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask : rd

    // random feedback position into slot k
    task automatic new_fb(input int k);
        seed = lfsr(seed);
        fb[k] = seed;
        u_ppl_probe_model.set_fb(seed);
    endtask : new_fb

    // one active then inactive level on pin i, new position before each
    task automatic pulse(input int i, input int k, input logic act);
        new_fb(k);
        u_ppl_probe_model.drive(i, act);
        tick(8);
        new_fb(k + 1);
        u_ppl_probe_model.drive(i, !act);
        tick(8);
    endtask : pulse

    task automatic finish_test;
        if (exp_q.size() != 0) num_errors++;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // read data stand one cycle after the strobe: compare with oldest note
    always @(posedge core_clk) begin
        if (rd_d) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("mismatch %0t: read without note", $time);
            end else begin
                exp_w = exp_q.pop_front();
                `CHK(reg_rdata, exp_w)
            end
        end
        rd_d <= reg_rd;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end

    // main sequence
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        seed = 32'hca20758c;
        tick(3);
        rst_n <= 1'b1;
        // reset values and an unmapped read
        for (int i = 0; i < 12; i++) begin
            rd(ra[i], (ra[i] == ADDR_PINSEL) ? 32'h4 : 32'h0);
        end
        // ch1 continuous, both edges, low active pin 0
        wr(ADDR_CTRL, 32'h33);
        pulse(0, 0, 1'b0);
        `CHK(irq, 1'b0)
        rd(ADDR_RISE1, fb[0]);
        rd(ADDR_FALL1, fb[1]);
        rd(ADDR_STAT, 32'h87);
        pulse(0, 2, 1'b0);
        rd(ADDR_RISE1, fb[2]);
        rd(ADDR_STAT, 32'h07);
        wr(ADDR_RISE1, ~fb[2]);
        rd(ADDR_RISE1, fb[2]);
        // unmask, read clears status, irq drops
        wr(ADDR_IRQ_MASK, 32'hf);
        tick(2);
        `CHK(irq, 1'b1)
        rd(ADDR_IRQ_STAT, 32'h3);
        tick(2);
        `CHK(irq, 1'b0)
        // ch2 single on encoder zero: second pulse ignored
        wr(ADDR_CTRL, 32'h3533);
        pulse(3, 4, 1'b1);
        pulse(3, 6, 1'b1);
        rd(ADDR_RISE2, fb[4]);
        rd(ADDR_FALL2, fb[5]);
        rd(ADDR_STAT, 32'h0707);
        rd(ADDR_IRQ_STAT, 32'hc);
        // restart ch1 on pin 2, high active, filter 50 ns
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_STAT, 32'h0);
        wr(ADDR_PINSEL, 32'h6);
        wr(ADDR_POL, 32'h1);
        wr(ADDR_FILT, 32'd2000);
        rd(ADDR_FILT, 32'd1000);
        wr(ADDR_FILT, 32'd5);
        wr(ADDR_CTRL, 32'h11);
        pulse(0, 7, 1'b0);
        u_ppl_probe_model.drive(2, 1'b0);
        tick(3);
        u_ppl_probe_model.drive(2, 1'b1);
        tick(12);
        rd(ADDR_RISE1, fb[2]);
        u_ppl_probe_model.drive(2, 1'b0);
        tick(20);
        new_fb(8);
        u_ppl_probe_model.drive(2, 1'b1);
        tick(20);
        rd(ADDR_RISE1, fb[8]);
        rd(ADDR_FALL1, fb[3]);
        tick(4);
        // mid-run reset: enable at once, no false edge from reset
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        wr(ADDR_CTRL, 32'h3337);
        tick(4);
        rd(ADDR_STAT, 32'h0101);
        rd(ADDR_FALL2, 32'h0);
        // ch1 on encoder zero, ch2 on pin 1 low active
        pulse(3, 0, 1'b1);
        pulse(1, 2, 1'b0);
        rd(ADDR_RISE1, fb[0]);
        rd(ADDR_FALL1, fb[1]);
        rd(ADDR_RISE2, fb[2]);
        rd(ADDR_FALL2, fb[3]);
        rd(ADDR_STAT, 32'h8787);
        rd(ADDR_IRQ_STAT, 32'hf);
        tick(4);
        finish_test();
    end
endmodule : tb_ppl_probe_latch
